// ---- ucd_alpha_decoder.sv ----
// Byte-serial alpha field decoder: record bytes in, characters out.
// Assumes bytes come from a record buffer on sys_clk with valid/ready and a
// last marker on the final byte of the record.
`default_nettype none
module ucd_alpha_decoder
   import ucd_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Byte input
   input  wire logic       in_valid,
   input  wire logic [7:0] in_byte,
   input  wire logic       in_last,
   output logic            in_ready,
   // Character output
   output logic            out_valid,
   output var ucd_char_t   out_char,
   output logic            out_end,
   output var ucd_coding_t out_coding
);
   ucd_state_t  state_reg,  state_next;
   ucd_coding_t coding_reg, coding_next;
   logic [7:0]  count_reg,  count_next;
   logic [15:0] base_reg,   base_next;
   logic [7:0]  hi_reg,     hi_next;
   logic        ov_reg,     ov_next;
   ucd_char_t   oc_reg,     oc_next;
   logic        oe_reg,     oe_next;
   ucd_char_t   mapped;
   logic        take;

   ucd_offset_map u_map (
      .byte_in (in_byte),
      .base    (base_reg),
      .ch      (mapped)
   );

   // Input is taken whenever in_valid is high; bytes past the end of text are swallowed until in_last
   assign take = in_valid;

   // ----------------------------------------------------------------
   // Decode state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      coding_next = coding_reg;
      count_next  = count_reg;
      base_next   = base_reg;
      hi_next     = hi_reg;
      ov_next     = 1'b0;
      oc_next     = oc_reg;
      oe_next     = 1'b0;
      if (take) begin
         unique case (state_reg)
            UCD_S_LEAD: begin
               if (in_byte == UCD_MARK_PAIR) begin
                  coding_next = UCD_C_PAIR;                    // [R1] [R10]
                  state_next  = UCD_S_BODY;
               end else if (in_byte == UCD_MARK_HALF) begin
                  coding_next = UCD_C_HALF;                    // [R3]
                  state_next  = UCD_S_COUNT;
               end else if (in_byte == UCD_MARK_FULL) begin
                  coding_next = UCD_C_FULL;                    // [R6]
                  state_next  = UCD_S_COUNT;
               end else begin
                  coding_next = UCD_C_PLAIN;                   // [R11]
                  ov_next     = 1'b1;
                  oc_next     = '{ucs2: 1'b0, code: {9'h000, in_byte[6:0]}};
                  state_next  = UCD_S_BODY;
               end
            end
            UCD_S_COUNT: begin
               count_next = in_byte;                           // [R3] [R6]
               state_next = UCD_S_BASEH;
            end
            UCD_S_BASEH: begin
               if (coding_reg == UCD_C_HALF) begin
                  base_next  = {1'b0, in_byte, 7'h00};         // [R4]
                  state_next = (count_reg == UCD_COUNT_RST) ? UCD_S_DONE : UCD_S_BODY;
               end else begin
                  base_next  = {in_byte, 8'h00};               // [R6]
                  state_next = UCD_S_BASEL;
               end
            end
            UCD_S_BASEL: begin
               base_next  = {base_reg[15:8], in_byte};         // [R6]
               state_next = (count_reg == UCD_COUNT_RST) ? UCD_S_DONE : UCD_S_BODY;
            end
            UCD_S_BODY: begin
               unique case (coding_reg)
                  UCD_C_PLAIN: begin
                     ov_next = 1'b1;                           // [R11]
                     oc_next = '{ucs2: 1'b0, code: {9'h000, in_byte[6:0]}};
                  end
                  UCD_C_PAIR: begin
                     if (in_byte == UCD_PAD) begin
                        state_next = UCD_S_DONE;               // [R2]
                     end else begin
                        hi_next    = in_byte;                  // [R1]
                        state_next = UCD_S_PAIRL;
                     end
                  end
                  UCD_C_HALF, UCD_C_FULL: begin
                     // 0xFF inside the count is a character, never padding
                     ov_next    = 1'b1;                        // [R5] [R7] [R8]
                     oc_next    = mapped;
                     count_next = count_reg - 8'h01;
                     if (count_reg == 8'h01) begin
                        state_next = UCD_S_DONE;               // [R3]
                     end
                  end
               endcase
            end
            UCD_S_PAIRL: begin
               ov_next    = 1'b1;
               oc_next    = '{ucs2: 1'b1, code: {hi_reg, in_byte}}; // [R1]
               state_next = UCD_S_BODY;
            end
            UCD_S_DONE: begin
               state_next = UCD_S_DONE;
            end
            default: begin
               state_next = UCD_S_DONE;
            end
         endcase
         // Record boundary resets the decoder for the next record
         if (in_last) begin
            state_next = UCD_S_LEAD;
            oe_next    = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= UCD_S_LEAD;
         coding_reg <= UCD_C_PLAIN;
         count_reg  <= UCD_COUNT_RST;
         base_reg   <= UCD_BASE_RST;
         hi_reg     <= 8'h00;
         ov_reg     <= 1'b0;
         oc_reg     <= '0;
         oe_reg     <= 1'b0;
      end else begin
         state_reg  <= state_next;
         coding_reg <= coding_next;
         count_reg  <= count_next;
         base_reg   <= base_next;
         hi_reg     <= hi_next;
         ov_reg     <= ov_next;
         oc_reg     <= oc_next;
         oe_reg     <= oe_next;
      end
   end

   // Ready is held high by a flop so downstream never stalls the buffer
   logic rdy_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_reg <= 1'b0;
      end else begin
         rdy_reg <= 1'b1;
      end
   end

   assign in_ready   = rdy_reg;
   assign out_valid  = ov_reg;
   assign out_char   = oc_reg;
   assign out_end    = oe_reg;
   assign out_coding = coding_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   pair_high_first_a: assert property (                                  // [R1]
      (state_reg == UCD_S_PAIRL && in_valid && !in_last)
      |=> out_valid && out_char.ucs2 && out_char.code == {$past(hi_reg), $past(in_byte)})
      else $error("pair character not high byte first");
   pad_ends_text_a: assert property (                                    // [R2]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_PAIR && in_valid && in_byte == UCD_PAD && !in_last)
      |=> state_reg == UCD_S_DONE ##1 !out_valid)
      else $error("pad byte did not end pair text");
   count_stop_a: assert property (                                       // [R3]
      (state_reg == UCD_S_DONE) |=> !out_valid)
      else $error("character after count reached");
   half_base_a: assert property (                                        // [R4]
      (state_reg == UCD_S_BASEH && coding_reg == UCD_C_HALF && in_valid && !in_last)
      |=> base_reg == {1'b0, $past(in_byte), 7'h00})
      else $error("half page base pointer wrong");
   half_body_a: assert property (                                        // [R5]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_HALF && in_valid && in_byte[7])
      |=> out_valid && out_char.ucs2 && out_char.code == $past(base_reg) + {9'h000, $past(in_byte[6:0])})
      else $error("offset character wrong");
   full_base_a: assert property (                                        // [R6]
      (state_reg == UCD_S_BASEL && in_valid && !in_last)
      |=> base_reg == {$past(base_reg[15:8]), $past(in_byte)})
      else $error("full base pointer wrong");
   full_plain_a: assert property (                                       // [R7]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_FULL && in_valid && !in_byte[7])
      |=> out_valid && !out_char.ucs2 && out_char.code == {9'h000, $past(in_byte[6:0])})
      else $error("default character under full base wrong");
   ff_valid_a: assert property (                                         // [R8]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_HALF && in_valid && in_byte == UCD_PAD)
      |=> out_valid && out_char.code == $past(base_reg) + 16'h007F)
      else $error("0xFF inside count not decoded");
   plain_lead_a: assert property (                                       // [R11] [R10]
      (state_reg == UCD_S_LEAD && in_valid && in_byte != UCD_MARK_PAIR
       && in_byte != UCD_MARK_HALF && in_byte != UCD_MARK_FULL)
      |=> out_valid && !out_char.ucs2 && out_char.code == {9'h000, $past(in_byte[6:0])})
      else $error("plain lead byte not passed");
   plain_body_a: assert property (                                       // [R11]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_PLAIN && in_valid)
      |=> out_valid && !out_char.ucs2 && out_char.code == {9'h000, $past(in_byte[6:0])})
      else $error("plain body byte not passed");
   full_body_a: assert property (                                        // [R7]
      (state_reg == UCD_S_BODY && coding_reg == UCD_C_FULL && in_valid && in_byte[7])
      |=> out_valid && out_char.ucs2 && out_char.code == $past(base_reg) + {9'h000, $past(in_byte[6:0])})
      else $error("offset character under full base wrong");
   record_end_a: assert property (                                       // [R9]
      out_end == $past(in_valid && in_last))
      else $error("record end pulse misplaced");

   pair_seen_c: cover property (state_reg == UCD_S_PAIRL ##1 out_valid);
   half_seen_c: cover property (coding_reg == UCD_C_HALF && out_valid && out_char.ucs2);
   full_seen_c: cover property (coding_reg == UCD_C_FULL && out_valid && out_char.ucs2);
   end_seen_c:  cover property (out_end);
   plain_seen_c: cover property (coding_reg == UCD_C_PLAIN && out_valid);
endmodule : ucd_alpha_decoder
`default_nettype wire

// ---- ucd_offset_map.sv ----
// Maps one body byte to a character under a base pointer.
// Assumes base pointer already assembled by the caller.
`default_nettype none
module ucd_offset_map
   import ucd_pkg::*;
(
   // Inputs
   input  wire logic [7:0]  byte_in,
   input  wire logic [15:0] base,
   // Result
   output var ucd_char_t    ch
);
   always_comb begin
      if (byte_in[7]) begin
         ch.ucs2 = 1'b1;
         ch.code = base + {9'h000, byte_in[6:0]};   // [R5] [R7] [R8]
      end else begin
         ch.ucs2 = 1'b0;
         ch.code = {9'h000, byte_in[6:0]};          // [R5] [R7]
      end
   end
endmodule : ucd_offset_map
`default_nettype wire

// ---- ucd_pkg.sv ----
// Package for the alpha field decoder: coding markers, carrier types, states.
// Assumes one 25 MHz clock domain; no software registers.
// Function
// R1: Leading byte 0x80 makes each following byte pair one 16-bit character, high byte first.
// R2: The encoder pads unused 0x80-coded bytes with 0xFF, and the decoder ends the text at that padding.
// R3: Leading byte 0x81 makes byte two the character count, and output stops when the count is reached.
// R4: Under 0x81 the third byte gives base pointer {0, byte, 7'b0}.
// R5: Under 0x81 each later byte gives a default-alphabet character if bit 7 is clear, else base plus low seven bits.
// R6: Leading byte 0x82 makes byte two the count and bytes three and four the full 16-bit base pointer.
// R7: Under 0x82 each byte from the fifth gives a default-alphabet character or base plus low seven bits.
// R8: Under 0x81 a 0xFF byte inside the count is a real character at base plus 0x7F, not padding.
// R9: The encoder uses one coding per record and none of the 16-bit codings for pure default-alphabet text.
// R10: All three 16-bit codings are decoded, so both small and large character sets are served.
// R11: Any other leading byte makes every byte a default-alphabet character, and each output is flagged by kind.
`default_nettype none
package ucd_pkg;
   localparam logic [7:0] UCD_MARK_PAIR  = 8'h80;
   localparam logic [7:0] UCD_MARK_HALF  = 8'h81;
   localparam logic [7:0] UCD_MARK_FULL  = 8'h82;
   localparam logic [7:0] UCD_PAD        = 8'hFF;
   localparam logic [7:0] UCD_COUNT_RST  = 8'h00;
   localparam logic [15:0] UCD_BASE_RST  = 16'h0000;

   typedef enum logic [2:0] {
      UCD_S_LEAD  = 3'b000,
      UCD_S_COUNT = 3'b001,
      UCD_S_BASEH = 3'b010,
      UCD_S_BASEL = 3'b011,
      UCD_S_BODY  = 3'b100,
      UCD_S_PAIRL = 3'b101,
      UCD_S_DONE  = 3'b110
   } ucd_state_t;

   typedef enum logic [1:0] {
      UCD_C_PLAIN = 2'b00,
      UCD_C_PAIR  = 2'b01,
      UCD_C_HALF  = 2'b10,
      UCD_C_FULL  = 2'b11
   } ucd_coding_t;

   // Decoded character: code point plus kind flag
   typedef struct packed {
      logic        ucs2;
      logic [15:0] code;
   } ucd_char_t;
endpackage : ucd_pkg
`default_nettype wire

// ---- ucs2_alpha_field_decoder_tb_top.sv ----
// Self-checking bench for the alpha field decoder: feeds whole records, checks characters.
// Assumes in_ready stays high after reset, so each byte is taken at the next rising edge.
`default_nettype none
module ucs2_alpha_field_decoder_tb_top
   import ucd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk;
   logic        rst_n;
   logic        in_valid;
   logic [7:0]  in_byte;
   logic        in_last;
   logic        in_ready;
   logic        out_valid;
   ucd_char_t   out_char;
   logic        out_end;
   ucd_coding_t out_coding;
   int          failures;
   int          checks_done;
   int          ends_seen;
   ucd_char_t   got_q[$];

   ucd_alpha_decoder dut (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (in_valid),
      .in_byte   (in_byte),
      .in_last   (in_last),
      .in_ready  (in_ready),
      .out_valid (out_valid),
      .out_char  (out_char),
      .out_end   (out_end),
      .out_coding(out_coding)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // Output capture: pulses stand one cycle, so sample mid-cycle
   // ---------------------------------------------------------------
   always @(negedge sys_clk) begin
      if (out_valid === 1'b1) got_q.push_back(out_char);
      if (out_end === 1'b1) ends_seen++;
   end

   task automatic tally_and_finish;
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cmp_char(input ucd_char_t got, input ucd_char_t exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: char got %h expected %h", $time, got, exp);
      end
   endtask : cmp_char

   task automatic cmp_coding(input ucd_coding_t got, input ucd_coding_t exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: coding got %h expected %h", $time, got, exp);
      end
   endtask : cmp_coding

   task automatic cmp_count(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         failures++;
         $display("CHECK FAILED at %0t: count got %h expected %h", $time, got, exp);
      end
   endtask : cmp_count

   // ---------------------------------------------------------------
   // Shared record driver and judge; bytes go back to back
   // ---------------------------------------------------------------
   task automatic run_record(input logic [7:0] b[$], input ucd_char_t e[$], input ucd_coding_t c);
      got_q.delete();
      ends_seen = 0;
      foreach (b[i]) begin
         @(negedge sys_clk);
         in_valid = 1'b1;
         in_byte  = b[i];
         in_last  = (i == b.size() - 1);
      end
      @(negedge sys_clk);
      in_valid = 1'b0;
      in_last  = 1'b0;
      repeat (3) @(negedge sys_clk);
      cmp_count(got_q.size(), e.size());
      foreach (e[i]) if (i < got_q.size()) cmp_char(got_q[i], e[i]);
      cmp_count(ends_seen, 1);
      cmp_coding(out_coding, c);
   endtask : run_record

   // Pairs high byte first; padding ends the text early
   task automatic test_pairs;
      run_record('{8'h80, 8'h09, 8'h95, 8'h00, 8'h41, 8'hFF, 8'hFF, 8'hFF},
                 '{17'h10995, 17'h10041}, UCD_C_PAIR);
   endtask : test_pairs

   // Half page: count stops output, 0xFF inside count is real
   task automatic test_half_page;
      run_record('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h5A, 8'hFF, 8'hFF},
                 '{17'h00053, 17'h10995, 17'h109A6, 17'h0005A, 17'h109FF}, UCD_C_HALF);
   endtask : test_half_page

   // Full base pointer taken from two bytes
   task automatic test_full_base;
      run_record('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31},
                 '{17'h0002D, 17'h10532, 17'h10583, 17'h0002D, 17'h00031}, UCD_C_FULL);
   endtask : test_full_base

   // Plain text: lead byte is the first character
   task automatic test_plain;
      run_record('{8'h41, 8'h42, 8'hFF}, '{17'h00041, 17'h00042, 17'h0007F}, UCD_C_PLAIN);
   endtask : test_plain

   // Record cut inside the header ends cleanly and yields nothing
   task automatic test_cut_header;
      ucd_char_t no_chars[$];
      run_record('{8'h82, 8'h03}, no_chars, UCD_C_FULL);
   endtask : test_cut_header

   // A zero count yields nothing even with body bytes present
   task automatic test_zero_count;
      ucd_char_t none[$];
      run_record('{8'h81, 8'h00, 8'h13, 8'h41, 8'hC1}, none, UCD_C_HALF);
   endtask : test_zero_count

   // ---------------------------------------------------------------
   // Watchdog: the whole run needs well under 300 cycles
   // ---------------------------------------------------------------
   initial begin
      #(40 * 2000);
      failures++;
      tally_and_finish();
   end

   initial begin
      failures    = 0;
      checks_done = 0;
      ends_seen   = 0;
      rst_n       = 1'b0;
      in_valid    = 1'b0;
      in_byte     = 8'h00;
      in_last     = 1'b0;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      checks_done++;
      if (in_ready !== 1'b1) begin
         failures++;
         $display("CHECK FAILED at %0t: ready got %h expected %h", $time, in_ready, 1'b1);
      end
      test_pairs();
      test_half_page();
      test_full_base();
      test_cut_header();
      test_plain();
      test_zero_count();
      tally_and_finish();
   end
endmodule : ucs2_alpha_field_decoder_tb_top
`default_nettype wire
